// *** rtl/pllrs_pkg.sv ***
// Constants, register map and encodings for the PLL reference switch and dividers
package pllrs_pkg;
   // ****************************************
   // Bus geometry
   // ****************************************
   localparam int APB_AW = 12;
   localparam int APB_DW = 32;
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 9;
   // ****************************************
   // Register indices (byte address = 4 x index)
   // ****************************************
   localparam logic [7:0] IDX_PLL_CTL = 8'h10;
   localparam logic [7:0] IDX_RDIV_LO = 8'h11;
   localparam logic [7:0] IDX_RDIV_HI = 8'h12;
   localparam logic [7:0] IDX_SWALLOW = 8'h13;
   localparam logic [7:0] IDX_MAIN_LO = 8'h14;
   localparam logic [7:0] IDX_MAIN_HI = 8'h15;
   localparam logic [7:0] IDX_PSC = 8'h16;
   localparam logic [7:0] IDX_SYNC_CTL = 8'h19;
   localparam logic [7:0] IDX_REF_CTL = 8'h1c;
   localparam logic [7:0] IDX_CTR_CTL = 8'h1e;
   localparam logic [7:0] IDX_STATUS = 8'h1f;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [1:0] RST_PLL_PD = 2'h1;
   localparam logic [7:0] RST_REF_CTL = 8'h00;
   // ****************************************
   // Field widths and bit positions
   // ****************************************
   localparam int RDIV_W = 14;
   localparam int MAIN_W = 13;
   localparam int SWAL_W = 6;
   localparam int PCNT_W = 6;
   localparam int NUM_IN = 5;
   localparam int IN_PRI = 0;
   localparam int IN_SEC = 1;
   localparam int IN_VCO = 2;
   localparam int IN_SEL = 3;
   localparam int IN_SYNC = 4;
   localparam int RC_DIFF = 0;
   localparam int RC_PRI_EN = 1;
   localparam int RC_SEC_EN = 2;
   localparam int RC_STAY = 3;
   localparam int RC_AUTO = 4;
   localparam int RC_PIN_SEL = 5;
   localparam int RC_REG_SEC = 6;
   localparam int RC_DGL_OFF = 7;
   localparam int SYNC_LSB = 6;
   localparam int ST_ACTIVE = 0;
   localparam int ST_MISSING = 1;
   localparam int ST_DIFF_PD = 2;
   localparam int ST_PRI_PD = 3;
   localparam int ST_SEC_PD = 4;
   localparam logic [1:0] MISS_LIMIT = 2'h2;
   localparam logic [2:0] REVERT_LAST = 3'h3;
   // ****************************************
   // Encodings
   // ****************************************
   typedef enum logic [2:0] {
      PSC_FD1 = 3'b000, PSC_FD2 = 3'b001, PSC_DM2 = 3'b010, PSC_DM4 = 3'b011,
      PSC_DM8 = 3'b100, PSC_DM16 = 3'b101, PSC_DM32 = 3'b110, PSC_FD3 = 3'b111
   } pllrs_psc_t;
   typedef enum logic [1:0] {
      SYNC_OFF = 2'b00, SYNC_LEVEL = 2'b01, SYNC_EDGE = 2'b10, SYNC_LEVEL2 = 2'b11
   } pllrs_sync_t;
endpackage

// *** rtl/pllrs_top.sv ***
// PLL reference selection, switchover and reference/feedback dividers with APB registers
// Notes on behaviour
// - Reference divider is 14 bits, 0 to 16383, from two registers, feeds detector.
// - Reference divider values zero and one both divide by one.
// - Reference divider cleared by shared counter reset bit and by sync.
// - Feedback division is modulus times main count plus swallow count.
// - Prescaler modes: fixed 1,2,3 and dual 2/3 to 32/33 by 3-bit field.
// - Fixed-divide mode ignores swallow counter; division is ratio times main.
// - Dual mode with swallow zero divides by base modulus only.
// - Main counter bypass value one, meant for fixed-divide mode.
// - Swallow zero really counts zero; software keeps main at three or bypass.
// - Swallow and main counters cleared by shared reset bit and by sync.
// - All reference inputs off after reset; software enables one.
// - Differential receiver down when PLL down or differential not chosen.
// - Single-ended buffer down on PLL down, own bit, or differential mode.
// - Manual selection by register bit or by select pin.
// - Prefer-primary auto mode leaves and returns to primary as it comes.
// - Stay mode leaves primary when lost and never returns by itself.
// - Primary missing after two secondary falls without primary transition.
// - Secondary takes over at the next secondary rising edge.
// - Revert after four primary rises without two secondary falls between.
// - Deglitch keeps misaligned edges from the detector on a switch.
// - Sync pin counter reset governed by 2-bit field, off after reset.
`timescale 1ns/1ps
module pllrs_top
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pllrs_pkg::APB_AW-1:0] paddr,
   input wire logic [pllrs_pkg::APB_DW-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [pllrs_pkg::APB_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Reference, feedback and control pins
   input wire logic primary_reference,
   input wire logic secondary_reference,
   input wire logic vco_clock,
   input wire logic ref_sel_pin,
   input wire logic sync_n_pin,
   // Phase detector feeds and buffer controls
   output logic ref_div_out,
   output logic fb_div_out,
   output logic active_ref_sec,
   output logic diff_rx_pd,
   output logic se_pri_pd,
   output logic se_sec_pd
);
   import pllrs_pkg::*;

   typedef struct packed {
      logic [NUM_IN-1:0] sy1;
      logic [NUM_IN-1:0] sy2;
      logic [NUM_IN-1:0] sy3;
      logic [NUM_IN-1:0] lvl;
      logic [NUM_IN-1:0] lvl_d;
      logic [1:0] pll_pd;
      logic [7:0] rdiv_lo;
      logic [RDIV_W-9:0] rdiv_hi;
      logic [SWAL_W-1:0] swal;
      logic [7:0] main_lo;
      logic [MAIN_W-9:0] main_hi;
      logic [2:0] psc;
      logic [1:0] sync_ctl;
      logic ctr_rst;
      logic [7:0] ref_ctl;
      logic [RDIV_W-1:0] rcnt;
      logic [PCNT_W-1:0] pcnt;
      logic [MAIN_W-1:0] bcnt;
      logic [1:0] miss;
      logic [2:0] rise;
      logic prim_missing;
      logic active;
      logic [APB_DW-1:0] prdata;
      logic pready;
      logic pslverr;
      logic rdiv_out;
      logic fb_out;
      logic diff_pd;
      logic pri_pd;
      logic sec_pd;
   } pllrs_state_t;

   pllrs_state_t s_reg;
   pllrs_state_t s_next;

   logic [7:0] idx;
   logic mapped;
   logic [7:0] rd_byte;
   logic wr_en;
   logic pll_pd;
   logic diff_sel;
   logic pri_ok;
   logic sec_ok;
   logic pri_rise;
   logic pri_tog;
   logic sec_rise;
   logic sec_fall;
   logic vco_rise;
   logic sync_fall;
   logic ctr_clr;
   logic monitor_on;
   logic target;
   logic act_n;
   logic [1:0] miss_n;
   logic ref_edge;
   logic [RDIV_W-1:0] r_val;
   logic [RDIV_W-1:0] r_eff;
   logic [MAIN_W-1:0] b_val;
   logic [MAIN_W-1:0] b_eff;
   logic dm;
   logic [PCNT_W-1:0] base;
   logic [PCNT_W-1:0] mod;

   always_comb begin
      s_next = s_reg;
      // ****************************************
      // Input synchronisers, 2-of-3 agreement
      // ****************************************
      s_next.sy1 = {sync_n_pin, ref_sel_pin, vco_clock, secondary_reference, primary_reference};
      s_next.sy2 = s_reg.sy1;
      s_next.sy3 = s_reg.sy2;
      s_next.lvl = (s_reg.sy2 & s_reg.sy3) | (s_reg.lvl & (s_reg.sy2 | s_reg.sy3));
      s_next.lvl_d = s_reg.lvl;

      // ****************************************
      // APB slave, no wait states
      // ****************************************
      idx = paddr[IDX_MSB:IDX_LSB];
      mapped = 1'b1;
      rd_byte = 8'h00;
      unique case (idx)
         IDX_PLL_CTL: rd_byte = {6'h00, s_reg.pll_pd};
         IDX_RDIV_LO: rd_byte = s_reg.rdiv_lo;
         IDX_RDIV_HI: rd_byte = {2'h0, s_reg.rdiv_hi};
         IDX_SWALLOW: rd_byte = {2'h0, s_reg.swal};
         IDX_MAIN_LO: rd_byte = s_reg.main_lo;
         IDX_MAIN_HI: rd_byte = {3'h0, s_reg.main_hi};
         IDX_PSC: rd_byte = {5'h00, s_reg.psc};
         IDX_SYNC_CTL: rd_byte = {s_reg.sync_ctl, 6'h00};
         IDX_REF_CTL: rd_byte = s_reg.ref_ctl;
         IDX_CTR_CTL: rd_byte = {7'h00, s_reg.ctr_rst};
         IDX_STATUS: rd_byte = {3'h0, s_reg.sec_pd, s_reg.pri_pd, s_reg.diff_pd,
                                s_reg.prim_missing, s_reg.active};
         default: mapped = 1'b0;
      endcase
      s_next.pready = psel & ~penable;
      if (psel && !penable) begin
         s_next.prdata = {24'h000000, rd_byte};
         s_next.pslverr = ~mapped;
      end
      wr_en = psel & penable & s_reg.pready & pwrite & ~s_reg.pslverr & pstrb[0];
      if (wr_en) begin
         unique case (idx)
            IDX_PLL_CTL: s_next.pll_pd = pwdata[1:0];
            IDX_RDIV_LO: s_next.rdiv_lo = pwdata[7:0];
            IDX_RDIV_HI: s_next.rdiv_hi = pwdata[RDIV_W-9:0];
            IDX_SWALLOW: s_next.swal = pwdata[SWAL_W-1:0];
            IDX_MAIN_LO: s_next.main_lo = pwdata[7:0];
            IDX_MAIN_HI: s_next.main_hi = pwdata[MAIN_W-9:0];
            IDX_PSC: s_next.psc = pwdata[2:0];
            IDX_SYNC_CTL: s_next.sync_ctl = pwdata[SYNC_LSB+1:SYNC_LSB];
            IDX_REF_CTL: s_next.ref_ctl = pwdata[7:0];
            IDX_CTR_CTL: s_next.ctr_rst = pwdata[0];
            default: ;
         endcase
      end

      // ****************************************
      // Buffer power and edge detection
      // ****************************************
      pll_pd = (s_reg.pll_pd != 2'h0);
      diff_sel = s_reg.ref_ctl[RC_DIFF];
      pri_ok = ~pll_pd & (diff_sel | s_reg.ref_ctl[RC_PRI_EN]);
      sec_ok = ~pll_pd & ~diff_sel & s_reg.ref_ctl[RC_SEC_EN];
      s_next.diff_pd = pll_pd | ~diff_sel;
      s_next.pri_pd = pll_pd | diff_sel | ~s_reg.ref_ctl[RC_PRI_EN];
      s_next.sec_pd = pll_pd | diff_sel | ~s_reg.ref_ctl[RC_SEC_EN];
      pri_rise = pri_ok & s_reg.lvl[IN_PRI] & ~s_reg.lvl_d[IN_PRI];
      pri_tog = pri_ok & (s_reg.lvl[IN_PRI] ^ s_reg.lvl_d[IN_PRI]);
      sec_rise = sec_ok & s_reg.lvl[IN_SEC] & ~s_reg.lvl_d[IN_SEC];
      sec_fall = sec_ok & ~s_reg.lvl[IN_SEC] & s_reg.lvl_d[IN_SEC];
      vco_rise = s_reg.lvl[IN_VCO] & ~s_reg.lvl_d[IN_VCO];
      sync_fall = ~s_reg.lvl[IN_SYNC] & s_reg.lvl_d[IN_SYNC];

      // Shared counter clear: register bit or sync pin
      ctr_clr = s_reg.ctr_rst;
      unique case (s_reg.sync_ctl)
         SYNC_OFF: ;
         SYNC_EDGE: ctr_clr = ctr_clr | sync_fall;
         SYNC_LEVEL, SYNC_LEVEL2: ctr_clr = ctr_clr | ~s_reg.lvl[IN_SYNC];
      endcase

      // ****************************************
      // Missing-primary monitor
      // ****************************************
      monitor_on = s_reg.ref_ctl[RC_AUTO] & ~diff_sel & ~pll_pd;
      miss_n = s_reg.miss;
      if (pri_tog) begin
         miss_n = 2'h0;
      end else if (sec_fall && s_reg.miss != MISS_LIMIT) begin
         miss_n = s_reg.miss + 2'h1;
      end
      s_next.miss = miss_n;
      if (!monitor_on) begin
         s_next.miss = 2'h0;
         s_next.rise = 3'h0;
         s_next.prim_missing = 1'b0;
      end else if (miss_n == MISS_LIMIT) begin
         s_next.prim_missing = 1'b1;
         s_next.rise = 3'h0;
      end else if (s_reg.prim_missing && pri_rise) begin
         if (s_reg.rise == REVERT_LAST) begin
            s_next.prim_missing = 1'b0;
            s_next.rise = 3'h0;
         end else begin
            s_next.rise = s_reg.rise + 3'h1;
         end
      end

      // ****************************************
      // Reference selection with deglitch
      // ****************************************
      if (diff_sel) begin
         target = 1'b0;
      end else if (s_reg.ref_ctl[RC_AUTO]) begin
         // Stay mode latches onto secondary once there
         target = s_next.prim_missing | (s_reg.ref_ctl[RC_STAY] & s_reg.active);
      end else if (s_reg.ref_ctl[RC_PIN_SEL]) begin
         target = s_reg.lvl[IN_SEL];
      end else begin
         target = s_reg.ref_ctl[RC_REG_SEC];
      end
      act_n = s_reg.active;
      if (target != s_reg.active) begin
         // Hand over on the new reference's rising edge, or at once if deglitch is off in manual mode
         if (s_reg.ref_ctl[RC_DGL_OFF] && !s_reg.ref_ctl[RC_AUTO]) begin
            act_n = target;
         end else if (target ? sec_rise : pri_rise) begin
            act_n = target;
         end
      end
      s_next.active = act_n;
      ref_edge = act_n ? sec_rise : pri_rise;

      // ****************************************
      // Reference divider
      // ****************************************
      r_val = {s_reg.rdiv_hi, s_reg.rdiv_lo};
      r_eff = (r_val < RDIV_W'(2)) ? RDIV_W'(1) : r_val;
      s_next.rdiv_out = 1'b0;
      if (ctr_clr) begin
         s_next.rcnt = '0;
      end else if (ref_edge) begin
         if (s_reg.rcnt >= r_eff - RDIV_W'(1)) begin
            s_next.rcnt = '0;
            s_next.rdiv_out = 1'b1;
         end else begin
            s_next.rcnt = s_reg.rcnt + RDIV_W'(1);
         end
      end

      // ****************************************
      // Feedback divider: prescaler, swallow, main
      // ****************************************
      dm = 1'b1;
      base = PCNT_W'(1);
      unique case (s_reg.psc)
         PSC_FD1: dm = 1'b0;
         PSC_FD2: begin
            dm = 1'b0;
            base = PCNT_W'(2);
         end
         PSC_FD3: begin
            dm = 1'b0;
            base = PCNT_W'(3);
         end
         PSC_DM2: base = PCNT_W'(2);
         PSC_DM4: base = PCNT_W'(4);
         PSC_DM8: base = PCNT_W'(8);
         PSC_DM16: base = PCNT_W'(16);
         PSC_DM32: base = PCNT_W'(32);
      endcase
      b_val = {s_reg.main_hi, s_reg.main_lo};
      b_eff = (b_val < MAIN_W'(2)) ? MAIN_W'(1) : b_val;
      // First swallow-count cycles stretched by one; swallow zero is a true zero
      mod = base;
      if (dm && (s_reg.bcnt < MAIN_W'(s_reg.swal))) begin
         mod = base + PCNT_W'(1);
      end
      s_next.fb_out = 1'b0;
      if (ctr_clr) begin
         s_next.pcnt = '0;
         s_next.bcnt = '0;
      end else if (vco_rise) begin
         if (s_reg.pcnt >= mod - PCNT_W'(1)) begin
            s_next.pcnt = '0;
            if (s_reg.bcnt >= b_eff - MAIN_W'(1)) begin
               s_next.bcnt = '0;
               s_next.fb_out = 1'b1;
            end else begin
               s_next.bcnt = s_reg.bcnt + MAIN_W'(1);
            end
         end else begin
            s_next.pcnt = s_reg.pcnt + PCNT_W'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
         s_reg.lvl <= {NUM_IN{1'b0}};
         s_reg.pll_pd <= RST_PLL_PD;
         s_reg.ref_ctl <= RST_REF_CTL;
         s_reg.sync_ctl <= SYNC_OFF;
         s_reg.diff_pd <= 1'b1;
         s_reg.pri_pd <= 1'b1;
         s_reg.sec_pd <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign ref_div_out = s_reg.rdiv_out;
   assign fb_div_out = s_reg.fb_out;
   assign active_ref_sec = s_reg.active;
   assign diff_rx_pd = s_reg.diff_pd;
   assign se_pri_pd = s_reg.pri_pd;
   assign se_sec_pd = s_reg.sec_pd;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_second_fall;
      monitor_on && sec_fall && !pri_tog && s_reg.miss == 2'h1;
   endsequence
   sequence s_fourth_rise;
      monitor_on && !s_reg.ref_ctl[RC_STAY] && s_reg.prim_missing && pri_rise
         && s_reg.rise == 3'h3 && miss_n != 2'h2;
   endsequence

   a_rdiv_unity: assert property (
      (!ctr_clr && ref_edge && r_val < 14'h0002) |=> ref_div_out)
      else $error("unity reference divide missed");
   a_rdiv_clear: assert property (
      ctr_clr |=> (s_reg.rcnt == 14'h0000 && !ref_div_out))
      else $error("reference counter not cleared");
   a_fb_clear: assert property (
      ctr_clr |=> (s_reg.pcnt == 6'h00 && s_reg.bcnt == 13'h0000 && !fb_div_out))
      else $error("feedback counters not cleared");
   a_fd_no_swallow: assert property (
      !dm |-> mod == base)
      else $error("swallow used in fixed mode");
   a_dm_zero_swal: assert property (
      (dm && s_reg.swal == 6'h00) |-> mod == base)
      else $error("swallow zero stretched prescaler");
   a_diff_power: assert property (
      (s_reg.pll_pd != 2'h0 || !s_reg.ref_ctl[RC_DIFF]) |=> diff_rx_pd)
      else $error("differential receiver left powered");
   a_se_power: assert property (
      (s_reg.pll_pd != 2'h0 || s_reg.ref_ctl[RC_DIFF] || !s_reg.ref_ctl[RC_PRI_EN])
         |=> se_pri_pd)
      else $error("primary buffer left powered");
   a_miss_declare: assert property (
      s_second_fall |=> s_reg.prim_missing)
      else $error("missing primary not declared");
   a_take_second: assert property (
      (s_reg.prim_missing && monitor_on && sec_rise && !s_reg.active) |=> active_ref_sec)
      else $error("secondary not taken at its rising edge");
   a_revert_prim: assert property (
      s_fourth_rise |=> (!s_reg.prim_missing && !active_ref_sec))
      else $error("no return to primary after four edges");
endmodule // pllrs_top

// *** bench/pllrs_src_model.sv ***
// Reference and VCO clock sources facing the PLL switch block
`timescale 1ns/1ps
module pllrs_src_model #(
   parameter int PRI_HALF = 4,
   parameter int SEC_HALF = 5,
   parameter int VCO_HALF = 3
) (
   // Clock
   input wire logic pclk,
   // Source controls
   input wire logic pri_run,
   input wire logic sec_run,
   // Clock outputs
   output logic primary_reference,
   output logic secondary_reference,
   output logic vco_clock
);
   int pc = 0;
   int sc = 0;
   int vc = 0;
   initial begin
      primary_reference = 1'b0;
      secondary_reference = 1'b0;
      vco_clock = 1'b0;
   end
   // ****************************************
   // Toggle generators
   // ****************************************
   // A stopped source finishes its high phase, then holds a driven low, never floats
   always @(posedge pclk) begin
      pc <= (pc + 1) % PRI_HALF;
      sc <= (sc + 1) % SEC_HALF;
      vc <= (vc + 1) % VCO_HALF;
      if (pc == PRI_HALF - 1 && (pri_run || primary_reference))
         primary_reference <= !primary_reference;
      if (sc == SEC_HALF - 1 && (sec_run || secondary_reference))
         secondary_reference <= !secondary_reference;
      if (vc == VCO_HALF - 1)
         vco_clock <= !vco_clock;
   end
endmodule // pllrs_src_model

// *** bench/pllrs_top_tb.sv ***
// Self-checking bench for the PLL reference switch and dividers
`timescale 1ns/1ps
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin err_total++; \
   $display("unexpected %s expected %0h seen %0h", nm, e, s); end end
module pllrs_top_tb;
   import pllrs_pkg::*;
   localparam int PH = 4;
   localparam int SH = 5;
   localparam int VH = 3;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
   logic [APB_AW-1:0] paddr;
   logic [APB_DW-1:0] pwdata, prdata, rd_data;
   logic [3:0] pstrb;
   logic ref_sel_pin, sync_n_pin, pri_run, sec_run, vco_clock;
   logic primary_reference, secondary_reference, ref_div_out, fb_div_out;
   logic active_ref_sec, diff_rx_pd, se_pri_pd, se_sec_pd;
   int err_total = 0;
   int comparisons = 0;
   int g, c, r, a, b, p, i;
   int ptab[8] = '{1, 2, 2, 4, 8, 16, 32, 3};
   int rtab[4] = '{0, 1, 2, 257};
   int ftab[3] = '{1, 3, 4};
   logic [7:0] pdc[5] = '{8'h01, 8'h06, 8'h02, 8'h04, 8'h07};
   logic [2:0] pde[5] = '{3'b011, 3'b100, 3'b101, 3'b110, 3'b011};
   pllrs_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .primary_reference, .secondary_reference, .vco_clock,
      .ref_sel_pin, .sync_n_pin, .ref_div_out, .fb_div_out, .active_ref_sec, .diff_rx_pd,
      .se_pri_pd, .se_sec_pd);
   pllrs_src_model #(.PRI_HALF(PH), .SEC_HALF(SH), .VCO_HALF(VH)) src (.pclk, .pri_run,
      .sec_run, .primary_reference, .secondary_reference, .vco_clock);
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // ****************************************
   // Bus and measurement tasks
   // ****************************************
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      // No wait-state count assumed; the watchdog ends a hung access
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [31:0] e);
      apb(1'b0, idx, 8'h00);
      `CHK("prdata", e, rd_data)
   endtask
   // First gap after a change is skipped, counters may be mid-period
   task automatic gap(input logic fb, output int gp);
      int n, f, k;
      gp = -1;
      for (k = 0; k < 2; k++) begin
         f = -1;
         gp = -1;
         for (n = 0; n < 5000 && gp < 0; n++) begin
            @(posedge pclk);
            if ((fb ? fb_div_out : ref_div_out) === 1'b1) begin
               if (f < 0) f = n;
               else gp = n - f;
            end
         end
      end
   endtask
   // Settling time covers the input synchronizer; feedback pulses counted only on request
   task automatic cnt(input logic fb, output int n);
      n = 0;
      repeat (8) @(posedge pclk);
      repeat (200) begin
         @(posedge pclk);
         if ((ref_div_out | (fb & fb_div_out)) === 1'b1) n++;
      end
   endtask
   task automatic wact(input logic e);
      int n;
      n = 0;
      while (active_ref_sec !== e && n < 300) begin
         @(posedge pclk);
         n++;
      end
      `CHK("active_ref_sec", e, active_ref_sec)
   endtask
   task automatic finish_test;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge pclk);
      err_total++;
      finish_test;
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {psel, penable, pwrite, paddr, pwdata, ref_sel_pin} = '0;
      {pstrb, sync_n_pin, pri_run, sec_run, presetn} = 8'hfe;
      void'($urandom(32'h9f08d0e9));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      `CHK("pd", 3'b111, {diff_rx_pd, se_pri_pd, se_sec_pd})
      rdchk(IDX_REF_CTL, 32'h0);
      rdchk(IDX_SYNC_CTL, 32'h0);
      rdchk(8'h00, 32'h0);
      `CHK("pslverr", 1'b1, rd_err)
      apb(1'b1, IDX_PLL_CTL, 8'h00);
      for (i = 0; i < 5; i++) begin
         apb(1'b1, IDX_REF_CTL, pdc[i]);
         repeat (3) @(posedge pclk);
         `CHK("pd", pde[i], {diff_rx_pd, se_pri_pd, se_sec_pd})
      end
      apb(1'b1, IDX_PLL_CTL, 8'h01);
      repeat (3) @(posedge pclk);
      `CHK("pd", 3'b111, {diff_rx_pd, se_pri_pd, se_sec_pd})
      apb(1'b1, IDX_PLL_CTL, 8'h00);
      apb(1'b1, IDX_REF_CTL, 8'h06);
      for (i = 0; i < 6; i++) begin
         r = (i < 4) ? rtab[i] : 3 + $urandom % 30;
         apb(1'b1, IDX_RDIV_LO, r[7:0]);
         apb(1'b1, IDX_RDIV_HI, {2'h0, r[13:8]});
         gap(1'b0, g);
         `CHK("ref_gap", ((r < 2) ? 1 : r) * 2 * PH, g)
      end
      for (i = 0; i < 8; i++) begin
         p = ptab[i];
         b = (i >= 2 && i <= 6) ? 3 + $urandom % 3 : ftab[$urandom % 3];
         a = (i == 3) ? 0 : $urandom % 3;
         apb(1'b1, IDX_SWALLOW, a[7:0]);
         apb(1'b1, IDX_MAIN_LO, b[7:0]);
         apb(1'b1, IDX_MAIN_HI, 8'h00);
         apb(1'b1, IDX_PSC, i[7:0]);
         gap(1'b1, g);
         if (i < 2 || i == 7) a = 0;
         `CHK("fb_gap", (p * b + a) * 2 * VH, g)
      end
      apb(1'b1, IDX_RDIV_LO, 8'h03);
      apb(1'b1, IDX_RDIV_HI, 8'h00);
      apb(1'b1, IDX_CTR_CTL, 8'h01);
      cnt(1'b1, c);
      `CHK("held_pulses", 0, c)
      apb(1'b1, IDX_CTR_CTL, 8'h00);
      for (i = 0; i < 4; i++) begin
         apb(1'b1, IDX_SYNC_CTL, {i[1:0], 6'h00});
         sync_n_pin <= 1'b0;
         cnt(1'b1, c);
         `CHK("sync_pulses", (i == 0 || i == 2), c > 0)
         sync_n_pin <= 1'b1;
      end
      apb(1'b1, IDX_SYNC_CTL, 8'h00);
      apb(1'b1, IDX_RDIV_LO, 8'h01);
      apb(1'b1, IDX_REF_CTL, 8'h46);
      wact(1'b1);
      gap(1'b0, g);
      `CHK("sec_gap", 2 * SH, g)
      apb(1'b1, IDX_REF_CTL, 8'h06);
      wact(1'b0);
      ref_sel_pin <= 1'b1;
      apb(1'b1, IDX_REF_CTL, 8'h26);
      wact(1'b1);
      ref_sel_pin <= 1'b0;
      wact(1'b0);
      sec_run <= 1'b0;
      repeat (30) @(posedge pclk);
      apb(1'b1, IDX_REF_CTL, 8'hc6);
      wact(1'b1);
      // The VCO keeps running, so only the reference path must stay silent
      cnt(1'b0, c);
      `CHK("dead_pulses", 0, c)
      sec_run <= 1'b1;
      apb(1'b1, IDX_REF_CTL, 8'h06);
      wact(1'b0);
      apb(1'b1, IDX_REF_CTL, 8'h16);
      pri_run <= 1'b0;
      repeat (8) @(posedge pclk);
      `CHK("early_switch", 1'b0, active_ref_sec)
      wact(1'b1);
      rdchk(IDX_STATUS, 32'h07);
      pri_run <= 1'b1;
      wact(1'b0);
      apb(1'b1, IDX_REF_CTL, 8'h1e);
      pri_run <= 1'b0;
      wact(1'b1);
      pri_run <= 1'b1;
      repeat (200) @(posedge pclk);
      `CHK("stay", 1'b1, active_ref_sec)
      apb(1'b1, IDX_REF_CTL, 8'h06);
      wact(1'b0);
      apb(1'b1, IDX_REF_CTL, 8'h1e);
      repeat (50) @(posedge pclk);
      `CHK("re_auto", 1'b0, active_ref_sec)
      finish_test;
   end
endmodule // pllrs_top_tb
